// >>> logic/ssr_pkg.sv
/*
 Package for the eight-stage shift/store register: widths and reset values.
 Assumes nothing of its surroundings.
*/
package ssr_pkg;
   localparam int         SSR_STAGES     = 8;
   localparam logic [7:0] SSR_STAGE_RST  = 8'h00;
   localparam logic       SSR_BIT_RST    = 1'b0;
   localparam int         SSR_CASC_IDX   = 6;   // Stage seven, zero based
   localparam int         SSR_BUF_DEPTH  = 2;
   localparam logic [0:0] SSR_PTR_ONE    = 1'h1;
endpackage

// >>> logic/ssr_shift_store.sv
/*
 Eight-stage shift register with store latches and three-state parallel
 outputs, plus fast and slow cascade outputs. The pin clock is sampled on
 clk; its edges become one-cycle enables. Strobe falls push a captured
 word through a two-entry buffer toward a word consumer.
 Assumes all inputs synchronous to clk (10 MHz) and a slow pin clock.
*/
`timescale 1ns/1ps
module ssr_shift_store
   import ssr_pkg::*;
#(
   parameter int N = SSR_STAGES
)(
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic         serial_in,
   input  wire logic         shift_clk,
   input  wire logic         strobe,
   input  wire logic         out_enable,
   output logic      [N-1:0] parallel_out_o,
   output logic      [N-1:0] parallel_out_oe,
   output logic              fast_serial_out,
   output logic              slow_serial_out,
   output logic      [N-1:0] word_data,
   output logic              word_valid,
   input  wire logic         word_ready,
   output logic              word_overrun
);
   logic [N-1:0] stage_r;
   logic [N-1:0] latch_r;
   logic         sclk_r;
   logic         strobe_r;
   logic         rise;
   logic         fall;
   logic         strobe_fall;
   logic         buf_in_ready;
   logic [N-1:0] buf_data;
   logic         buf_valid;
   logic         buf_pop;
   logic         stage_seven_value;

   ////////////////////////////////////////////////////////////////////////
   // Level now high, last sample low; shared by all three edge detectors
   function automatic logic ssr_edge(input logic now_lvl, input logic prev_lvl);
      return now_lvl && !prev_lvl;
   endfunction

   // Edge enables from the sampled pin clock and strobe
   assign rise              = ssr_edge(shift_clk, sclk_r);
   assign fall              = ssr_edge(sclk_r, shift_clk);
   assign strobe_fall       = ssr_edge(strobe_r, strobe);
   assign stage_seven_value = stage_r[SSR_CASC_IDX];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclk_r   <= SSR_BIT_RST;
         strobe_r <= SSR_BIT_RST;
      end else begin
         sclk_r   <= shift_clk;
         strobe_r <= strobe;
      end
   end

   // Shift chain; stage one is bit 0
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage_r <= SSR_STAGE_RST;
      end else if (rise) begin
         stage_r <= {stage_r[N-2:0], serial_in};
      end
   end

   // Fast cascade output, a copy of the last stage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fast_serial_out <= SSR_BIT_RST;
      end else if (rise) begin
         fast_serial_out <= stage_seven_value;
      end
   end

   // Slow cascade output, half a shift clock later for slow links
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         slow_serial_out <= SSR_BIT_RST;
      end else if (fall) begin
         slow_serial_out <= fast_serial_out;
      end
   end

   // Store latches; transparency sees the post-shift stages a cycle late
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         latch_r <= SSR_STAGE_RST;
      end else if (strobe) begin
         latch_r <= stage_r;
      end else if (strobe_fall) begin
         latch_r <= stage_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Three-state parallel pins; enable only gates drive, never the data
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         parallel_out_o  <= SSR_STAGE_RST;
         parallel_out_oe <= SSR_STAGE_RST;
      end else begin
         parallel_out_o  <= latch_r;
         parallel_out_oe <= {N{out_enable}};
      end
   end

   // Captured words buffered; a full buffer drops and flags the word
   ssr_skid_buf #(.WIDTH(N)) u_buf (
      .clk       (clk),
      .reset     (reset),
      .in_data   (stage_r),
      .in_valid  (strobe_fall),
      .in_ready  (buf_in_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop)
   );

   assign buf_pop = buf_valid && (!word_valid || word_ready);

   // Registered word output stage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         word_data    <= SSR_STAGE_RST;
         word_valid   <= SSR_BIT_RST;
         word_overrun <= SSR_BIT_RST;
      end else begin
         if (buf_pop) begin
            word_data <= buf_data;
         end
         if (buf_pop) begin
            word_valid <= 1'b1;
         end else if (word_ready) begin
            word_valid <= 1'b0;
         end
         word_overrun <= strobe_fall && !buf_in_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_shift;
      @(posedge clk) disable iff (reset)
      rise |=> stage_r == {$past(stage_r[N-2:0]), $past(serial_in)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");

   property p_fast;
      @(posedge clk) disable iff (reset)
      rise |=> fast_serial_out == stage_r[N-1];
   endproperty
   a_fast: assert property (p_fast) else $error("fast out wrong");

   property p_slow_hold;
      @(posedge clk) disable iff (reset)
      !fall |=> $stable(slow_serial_out);
   endproperty
   a_slow_hold: assert property (p_slow_hold) else $error("slow moved");

   property p_slow_upd;
      @(posedge clk) disable iff (reset)
      fall |=> slow_serial_out == $past(fast_serial_out);
   endproperty
   a_slow_upd: assert property (p_slow_upd) else $error("slow wrong");

   property p_hold;
      @(posedge clk) disable iff (reset)
      (!strobe && !strobe_fall) |=> $stable(latch_r);
   endproperty
   a_hold: assert property (p_hold) else $error("latch moved");

   property p_transp;
      @(posedge clk) disable iff (reset)
      strobe |=> ##1 parallel_out_o == $past(stage_r, 2);
   endproperty
   a_transp: assert property (p_transp) else $error("not transparent");

   property p_oe;
      @(posedge clk) disable iff (reset)
      1'b1 |=> parallel_out_oe == {N{$past(out_enable)}};
   endproperty
   a_oe: assert property (p_oe) else $error("enable wrong");

   property p_serial_free;
      @(posedge clk) disable iff (reset)
      (rise && !out_enable && !strobe) |=> fast_serial_out == $past(stage_r[SSR_CASC_IDX]);
   endproperty
   a_serial_free: assert property (p_serial_free) else $error("serial gated");

   c_shift:   cover property (@(posedge clk) disable iff (reset) rise ##[1:50] fall);
   c_capture: cover property (@(posedge clk) disable iff (reset) strobe_fall);
   c_float:   cover property (@(posedge clk) disable iff (reset) !out_enable && rise);
endmodule

// >>> logic/ssr_skid_buf.sv
/*
 Two-entry buffer with valid/ready on both sides, carries parallel words.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module ssr_skid_buf
   import ssr_pkg::*;
#(
   parameter int WIDTH = 8
)(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] mem_r [SSR_BUF_DEPTH];
   logic [0:0]       wr_ptr_r;
   logic [0:0]       rd_ptr_r;
   logic [1:0]       count_r;
   logic             push;
   logic             pop;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes; full refuses input so a stalled reader loses nothing
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (count_r != 2'(SSR_BUF_DEPTH));
   assign out_valid = (count_r != 2'h0);
   assign out_data  = mem_r[rd_ptr_r];

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_r <= 1'h0;
         rd_ptr_r <= 1'h0;
         count_r  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + SSR_PTR_ONE;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + SSR_PTR_ONE;
         end
         count_r <= count_r + 2'(push) - 2'(pop);
      end
   end
endmodule

// >>> tb/shift_store_register_8bit_tb_top.sv
/*
 Self-checking bench for the shift/store register and its word buffer.
 Assumes the controller model in its own file and the design package.
*/
`timescale 1ns/1ps
module shift_store_register_8bit_tb_top;
   import ssr_pkg::*;
   logic       clk, reset, serial_in, shift_clk, strobe, out_enable;
   logic [7:0] parallel_out_o, parallel_out_oe, word_data;
   logic       fast_serial_out, slow_serial_out, word_valid, word_ready, word_overrun;
   logic       hold_ready;
   logic [31:0] rnd, rnd_rdy;
   logic [7:0] latched;
   logic [7:0] exp_q[$];
   int         mismatches, num_checks;
   ////////////////////////////////////////////////////////////////////////////
   ssr_ctrl_model ctrl (.clk(clk), .serial_in(serial_in), .shift_clk(shift_clk),
      .strobe(strobe), .out_enable(out_enable));
   ssr_shift_store dut (.clk(clk), .reset(reset), .serial_in(serial_in),
      .shift_clk(shift_clk), .strobe(strobe), .out_enable(out_enable),
      .parallel_out_o(parallel_out_o), .parallel_out_oe(parallel_out_oe),
      .fast_serial_out(fast_serial_out), .slow_serial_out(slow_serial_out),
      .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
      .word_overrun(word_overrun));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One byte: shift with strobe held high or low, then capture on the fall
   task automatic run_byte(input logic [7:0] b, input logic transp, input logic en,
                           input int slow);
      ctrl.set_enable(en);
      if (transp) ctrl.set_strobe(1'b1);
      ctrl.send_byte(b, slow);
      repeat (4) @(negedge clk);
      check(fast_serial_out, b[7]);
      check(slow_serial_out, b[7]);
      check(parallel_out_oe, {8{en}});
      if (en) check(parallel_out_o, transp ? b : latched);
      if (!transp) ctrl.set_strobe(1'b1);
      repeat (2) @(negedge clk);
      ctrl.set_strobe(1'b0);
      exp_q.push_back(b);
      latched = b;
      repeat (4) @(negedge clk);
      if (en) check(parallel_out_o, b);
      ctrl.set_strobe(1'b0);
      repeat (3) @(negedge clk);
      if (en) check(parallel_out_o, b);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Consumer ready is random; held low for two bytes, stalling the output stage and one buffer entry
   always @(negedge clk) begin
      rnd_rdy <= xs(rnd_rdy);
      word_ready <= hold_ready ? 1'b0 : rnd_rdy[3];
   end
   // Accepted words are compared with the oldest note
   always @(posedge clk) begin
      if (!reset && word_valid === 1'b1 && word_ready === 1'b1) begin
         if (exp_q.size() == 0) check(word_data, ~word_data);
         else check(word_data, exp_q.pop_front());
      end
      if (!reset && word_overrun !== 1'b0) check({7'h00, word_overrun}, 8'h00);
   end
   // Watchdog well beyond the longest run; a hang ends as a failure
   initial begin
      #2_000_000;
      mismatches++;
      complete_run();
   end
   // Main sequence
   initial begin
      reset = 1'b1;
      hold_ready = 1'b0;
      rnd = 32'h4ea2;
      rnd_rdy = 32'h4ea2;
      latched = SSR_STAGE_RST;
      mismatches = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      repeat (2) @(negedge clk);
      for (int n = 0; n < 14; n++) begin
         rnd = xs(rnd);
         hold_ready = (n == 4 || n == 5);
         run_byte(rnd[7:0], rnd[8], rnd[9] | (n < 2), int'(rnd[11:10]));
      end
      hold_ready = 1'b0;
      for (int w = 0; w < 200 && exp_q.size() != 0; w++) @(negedge clk);
      if (exp_q.size() != 0) check(8'h01, 8'h00);
      complete_run();
   end
endmodule

// >>> tb/ssr_ctrl_model.sv
/*
 Controller model: drives serial data, pin shift clock, strobe and enable.
 Assumes a free-running clk; all pins change on its falling edge.
*/
`timescale 1ns/1ps
module ssr_ctrl_model (
   input  wire logic clk,
   output logic      serial_in,
   output logic      shift_clk,
   output logic      strobe,
   output logic      out_enable
);
   // Quiet pins from time zero
   initial begin
      serial_in  = 1'b0;
      shift_clk  = 1'b0;
      strobe     = 1'b0;
      out_enable = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // First bit sent ends in the last stage; stale data inverted, not held
   task automatic send_byte(input logic [7:0] b, input int slow);
      for (int i = 7; i >= 0; i--) begin
         @(negedge clk) serial_in = b[i];
         repeat (1 + slow) @(negedge clk);
         shift_clk = 1'b1;
         repeat (1 + slow) @(negedge clk);
         shift_clk = 1'b0;
         serial_in = ~b[i];
      end
   endtask
   // Strobe level handling, kept apart so the bench can hold it high
   task automatic set_strobe(input logic s);
      @(negedge clk) strobe = s;
   endtask
   task automatic set_enable(input logic en);
      @(negedge clk) out_enable = en;
   endtask
endmodule
